// *** rtl/spm_regs.vh ***
`ifndef SPM_REGS_VH
`define SPM_REGS_VH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define SPM_ADDR_GCTRL   8'h0e
`define SPM_ADDR_SLEEP   8'h0f
`define SPM_ADDR_STAT    8'h10
`define SPM_ADDR_PCTRL0  8'h1d
`define SPM_ADDR_PCTRL1  8'h2d
`define SPM_ADDR_MIIM0   8'h40
`define SPM_ADDR_MIIM1   8'h41

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SPM_MODE_LSB     3
`define SPM_MODE_MSB     4
`define SPM_ANEN_BIT     5
`define SPM_PPD_BIT      3
`define SPM_MIIM_PD_BIT  11

// ----------------------------------------
// Power mode encodings
// ----------------------------------------
`define SPM_MODE_NORMAL  2'h0
`define SPM_MODE_EDET    2'h1
`define SPM_MODE_SPD     2'h2
`define SPM_MODE_PSAVE   2'h3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SPM_GCTRL_RST    16'h0020
`define SPM_SLEEP_RST    8'h50
`define SPM_PCTRL_RST    16'h0000
`define SPM_MIIM_RST     16'h0000

// ----------------------------------------
// Timing
// ----------------------------------------
`define SPM_CLK_MHZ        100
`define SPM_LP_WIDTH_NS    120
`define SPM_LP_WIDTH_CYC   ((`SPM_LP_WIDTH_NS * `SPM_CLK_MHZ + 999) / 1000)
`define SPM_LP_PERIOD_MS   1000
`define SPM_LP_PERIOD_CYC  (`SPM_LP_PERIOD_MS * 1000 * `SPM_CLK_MHZ)
`define SPM_SLEEP_UNIT_US  1000
`define SPM_SLEEP_UNIT_CYC (`SPM_SLEEP_UNIT_US * `SPM_CLK_MHZ)
`define SPM_SRST_CYC       5'h10

`endif

// *** rtl/spm_pin_filt.v ***
`timescale 1ns/10ps
// ----------------------------------------
// Three-stage pin synchroniser, agree filter
// ----------------------------------------
module spm_pin_filt #(
  parameter W = 5
) (
  // Clock and reset
  input  wire         clk_in,
  input  wire         rst_n_in,
  input  wire         clk_en_in,
  // Pins and filtered levels
  input  wire [W-1:0] pin_in,
  output reg  [W-1:0] level_out
);

  reg [W-1:0] s1_ff;
  reg [W-1:0] s2_ff;
  reg [W-1:0] s3_ff;

  // First stage is read only by the second
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s1_ff     <= {W{1'b0}};
      s2_ff     <= {W{1'b0}};
      s3_ff     <= {W{1'b0}};
      level_out <= {W{1'b0}};
    end else if (clk_en_in) begin
      s1_ff     <= pin_in;
      s2_ff     <= s1_ff;
      s3_ff     <= s2_ff;
      level_out <= (s2_ff & s3_ff) | (level_out & (s2_ff | s3_ff));
    end
  end

endmodule // spm_pin_filt

// *** rtl/spm_power_ctrl.v ***
`timescale 1ns/10ps
`include "spm_regs.vh"
// What this block does
// RULE1: Mode field bits 4:3 selects four modes
// RULE2: Port bit3 or PHY bit11 powers port down
// RULE3: Mode field resets to normal
// RULE4: Normal mode: clocks, PHY, MAC, host on
// RULE5: Normal or saving mode may switch anywhere
// RULE6: Energy detect idle: 120ns pulse each second
// RULE7: Sleep after idle longer than go-sleep time
// RULE8: Low-power state keeps only energy detector
// RULE9: Cable energy returns to normal-power state
// RULE10: Soft power-down stops clocks, PHYs, MACs
// RULE11: Host access wakes, internal reset to defaults
// RULE12: Saving mode: 11, autoneg on, cable off
// RULE13: Saving mode: transmit on, unused receiver off
// RULE14: Saving mode: cable activity powers PHY up
// RULE15: Wake detector independent of stopped clocks
// RULE16: Go-sleep counted in fixed units, restarts
module spm_power_ctrl #(
  parameter [31:0] SLEEP_UNIT_CYC = `SPM_SLEEP_UNIT_CYC,
  parameter [31:0] LP_PERIOD_CYC  = `SPM_LP_PERIOD_CYC
) (
  // Clock and reset
  input  wire        sys_clk_in,
  input  wire        rst_n_in,
  input  wire        clk_en_in,
  // Register port
  input  wire [7:0]  reg_addr_in,
  input  wire [15:0] reg_wdata_in,
  input  wire        reg_wr_in,
  input  wire        reg_rd_in,
  output reg  [15:0] reg_rdata_out,
  // Line status pins, per port, and host select pin
  input  wire [1:0]  energy_in,
  input  wire [1:0]  link_up_in,
  input  wire        host_sel_in,
  // Power controls
  output reg         pll_en_out,
  output reg         mac_en_out,
  output reg         host_if_en_out,
  output reg  [1:0]  phy_pd_out,
  output reg  [1:0]  phy_rx_idle_off_out,
  output reg         ed_only_out,
  output reg         link_pulse_out,
  output reg         int_rst_out
);

  // ----------------------------------------
  // Registers and state
  // ----------------------------------------
  reg  [15:0] gctrl_ff;
  reg  [7:0]  sleep_ff;
  reg  [15:0] pctrl0_ff;
  reg  [15:0] pctrl1_ff;
  reg  [15:0] miim0_ff;
  reg  [15:0] miim1_ff;
  reg         ed_sleep_ff;
  reg  [31:0] unit_cnt_ff;
  reg  [8:0]  idle_units_ff;
  reg  [31:0] lp_cnt_ff;
  reg  [4:0]  srst_cnt_ff;
  reg         sel_prev_ff;
  wire [4:0]  filt_lvl;
  wire [1:0]  energy;
  wire [1:0]  link_up;
  wire        host_sel;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  spm_pin_filt #(
    .W (5)
  ) u_pin_filt (
    .clk_in    (sys_clk_in),
    .rst_n_in  (rst_n_in),
    .clk_en_in (clk_en_in),
    .pin_in    ({host_sel_in, link_up_in, energy_in}),
    .level_out (filt_lvl)
  );

  assign energy   = filt_lvl[1:0];
  assign link_up  = filt_lvl[3:2];
  assign host_sel = filt_lvl[4];

  // ----------------------------------------
  // Mode decode
  // ----------------------------------------
  function is_mode;
    input [15:0] ctrl;
    input [1:0]  code;
    begin
      is_mode = (ctrl[`SPM_MODE_MSB:`SPM_MODE_LSB] == code); // RULE1
    end
  endfunction

  function port_pd;
    input [15:0] pctrl;
    input [15:0] miim;
    begin
      port_pd = pctrl[`SPM_PPD_BIT] | miim[`SPM_MIIM_PD_BIT]; // RULE2
    end
  endfunction

  wire mode_norm  = is_mode(gctrl_ff, `SPM_MODE_NORMAL);
  wire mode_edet  = is_mode(gctrl_ff, `SPM_MODE_EDET);
  wire mode_spd   = is_mode(gctrl_ff, `SPM_MODE_SPD);
  wire mode_psave = is_mode(gctrl_ff, `SPM_MODE_PSAVE);
  wire an_en      = gctrl_ff[`SPM_ANEN_BIT];
  wire ed_low     = mode_edet & ed_sleep_ff;
  wire any_energy = |energy;

  // Host logic is alive in every mode but soft power-down and energy sleep
  wire hif_alive  = ~mode_spd & ~ed_low;
  // Pin select edge: checked on the always-on reference, not on the PLL clocks
  wire sel_rise   = host_sel & ~sel_prev_ff; // RULE15
  wire wake       = mode_spd & (reg_wr_in | reg_rd_in | sel_rise); // RULE11
  wire wr_ok      = reg_wr_in & hif_alive;
  wire rd_ok      = reg_rd_in & hif_alive;

  // ----------------------------------------
  // Register writes and internal reset
  // ----------------------------------------
  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      gctrl_ff    <= `SPM_GCTRL_RST; // RULE3
      sleep_ff    <= `SPM_SLEEP_RST;
      pctrl0_ff   <= `SPM_PCTRL_RST;
      pctrl1_ff   <= `SPM_PCTRL_RST;
      miim0_ff    <= `SPM_MIIM_RST;
      miim1_ff    <= `SPM_MIIM_RST;
      srst_cnt_ff <= 5'h00;
      sel_prev_ff <= 1'b0;
    end else if (clk_en_in) begin
      sel_prev_ff <= host_sel;
      if (srst_cnt_ff != 5'h00) begin
        srst_cnt_ff <= srst_cnt_ff - 5'h01;
      end
      if (wake) begin
        // Waking access is swallowed; every register returns to default
        gctrl_ff    <= `SPM_GCTRL_RST; // RULE11
        sleep_ff    <= `SPM_SLEEP_RST;
        pctrl0_ff   <= `SPM_PCTRL_RST;
        pctrl1_ff   <= `SPM_PCTRL_RST;
        miim0_ff    <= `SPM_MIIM_RST;
        miim1_ff    <= `SPM_MIIM_RST;
        srst_cnt_ff <= `SPM_SRST_CYC;
      end else if (wr_ok) begin
        case (reg_addr_in)
          `SPM_ADDR_GCTRL: begin
            gctrl_ff <= reg_wdata_in; // RULE5
          end
          `SPM_ADDR_SLEEP: begin
            sleep_ff <= reg_wdata_in[7:0];
          end
          `SPM_ADDR_PCTRL0: begin
            pctrl0_ff <= reg_wdata_in;
          end
          `SPM_ADDR_PCTRL1: begin
            pctrl1_ff <= reg_wdata_in;
          end
          `SPM_ADDR_MIIM0: begin
            miim0_ff <= reg_wdata_in;
          end
          `SPM_ADDR_MIIM1: begin
            miim1_ff <= reg_wdata_in;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // Energy detect: go-sleep timer
  // ----------------------------------------
  wire unit_tick = (unit_cnt_ff == SLEEP_UNIT_CYC - 32'h1);

  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ed_sleep_ff   <= 1'b0;
      unit_cnt_ff   <= 32'h0;
      idle_units_ff <= 9'h000;
    end else if (clk_en_in) begin
      if (!mode_edet || any_energy) begin
        // Energy or leaving the mode restarts the idle count
        unit_cnt_ff   <= 32'h0; // RULE16
        idle_units_ff <= 9'h000;
        ed_sleep_ff   <= 1'b0; // RULE9
      end else begin
        unit_cnt_ff <= unit_tick ? 32'h0 : unit_cnt_ff + 32'h1; // RULE16
        if (unit_tick && idle_units_ff != 9'h1ff) begin
          idle_units_ff <= idle_units_ff + 9'h001;
        end
        if (idle_units_ff > {1'b0, sleep_ff}) begin
          ed_sleep_ff <= 1'b1; // RULE7
        end
      end
    end
  end

  // ----------------------------------------
  // Energy detect: link pulse generator
  // ----------------------------------------
  wire lp_wrap = (lp_cnt_ff == LP_PERIOD_CYC - 32'h1);

  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      lp_cnt_ff <= 32'h0;
    end else if (clk_en_in) begin
      if (!mode_edet || any_energy) begin
        lp_cnt_ff <= 32'h0;
      end else begin
        lp_cnt_ff <= lp_wrap ? 32'h0 : lp_cnt_ff + 32'h1; // RULE6
      end
    end
  end

  // ----------------------------------------
  // Power outputs, all registered
  // ----------------------------------------
  wire       psave_on   = mode_psave & an_en; // RULE12
  wire       run_core   = mode_norm | psave_on | (mode_psave & ~an_en) | (mode_edet & ~ed_sleep_ff);
  wire [1:0] nxt_rx_off;
  wire [1:0] nxt_pd;
  wire       nxt_pulse;

  // Receiver trimmed only while the port is dark; activity restores it
  assign nxt_rx_off = {2{psave_on}} & ~link_up & ~energy; // RULE13 RULE14
  assign nxt_pd     = {port_pd(pctrl1_ff, miim1_ff), port_pd(pctrl0_ff, miim0_ff)}
                      | {2{mode_spd}}; // RULE10
  assign nxt_pulse  = mode_edet & ~any_energy
                      & (lp_cnt_ff < `SPM_LP_WIDTH_CYC); // RULE6

  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pll_en_out          <= 1'b1;
      mac_en_out          <= 1'b1;
      host_if_en_out      <= 1'b1;
      phy_pd_out          <= 2'h0;
      phy_rx_idle_off_out <= 2'h0;
      ed_only_out         <= 1'b0;
      link_pulse_out      <= 1'b0;
      int_rst_out         <= 1'b0;
    end else if (clk_en_in) begin
      pll_en_out          <= run_core & ~wake; // RULE4 RULE8 RULE10
      mac_en_out          <= run_core & ~wake; // RULE4 RULE8 RULE10
      host_if_en_out      <= run_core; // RULE4 RULE8
      phy_pd_out          <= nxt_pd; // RULE2
      phy_rx_idle_off_out <= nxt_rx_off; // RULE13
      ed_only_out         <= ed_low; // RULE8
      link_pulse_out      <= nxt_pulse;
      int_rst_out         <= wake | (srst_cnt_ff > 5'h01); // RULE11
    end
  end

  // ----------------------------------------
  // Read path: data valid only the cycle after
  // ----------------------------------------
  wire [15:0] stat_word = {6'h00, link_up, energy, phy_rx_idle_off_out, 1'b0,
                           ed_sleep_ff, gctrl_ff[`SPM_MODE_MSB:`SPM_MODE_LSB]};

  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= 16'h0000;
    end else if (clk_en_in) begin
      if (rd_ok) begin
        case (reg_addr_in)
          `SPM_ADDR_GCTRL: begin
            reg_rdata_out <= gctrl_ff;
          end
          `SPM_ADDR_SLEEP: begin
            reg_rdata_out <= {8'h00, sleep_ff};
          end
          `SPM_ADDR_STAT: begin
            reg_rdata_out <= stat_word;
          end
          `SPM_ADDR_PCTRL0: begin
            reg_rdata_out <= pctrl0_ff;
          end
          `SPM_ADDR_PCTRL1: begin
            reg_rdata_out <= pctrl1_ff;
          end
          `SPM_ADDR_MIIM0: begin
            reg_rdata_out <= miim0_ff;
          end
          `SPM_ADDR_MIIM1: begin
            reg_rdata_out <= miim1_ff;
          end
          default: begin
            reg_rdata_out <= 16'h0000;
          end
        endcase
      end else begin
        reg_rdata_out <= 16'h0000;
      end
    end
  end

endmodule // spm_power_ctrl

// *** verif/spm_power_chk.sv ***
`timescale 1ns/10ps
// ----------------------------------------
// Power controller port checker
// ----------------------------------------
module spm_power_chk #(
  parameter [31:0] SLEEP_UNIT_CYC = 4,
  parameter [31:0] LP_PERIOD_CYC  = 40
) (
  // Clock, reset, register port
  input wire        sys_clk_in,
  input wire        rst_n_in,
  input wire        clk_en_in,
  input wire [7:0]  reg_addr_in,
  input wire [15:0] reg_wdata_in,
  input wire        reg_wr_in,
  input wire        reg_rd_in,
  input wire [15:0] reg_rdata_out,
  // Line pins and power controls
  input wire [1:0]  energy_in,
  input wire [1:0]  link_up_in,
  input wire        host_sel_in,
  input wire        pll_en_out,
  input wire        mac_en_out,
  input wire        host_if_en_out,
  input wire [1:0]  phy_pd_out,
  input wire [1:0]  phy_rx_idle_off_out,
  input wire        ed_only_out,
  input wire        link_pulse_out,
  input wire        int_rst_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);

  // Raw idle time is never shorter than the filtered one
  reg [31:0] idle_cnt_ff;
  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) idle_cnt_ff <= 32'h0;
    else if (|energy_in) idle_cnt_ff <= 32'h0;
    else if (idle_cnt_ff != 32'hffffffff) idle_cnt_ff <= idle_cnt_ff + 32'h1;
  end

  sequence s_rst_half;
    int_rst_out [*8];
  endsequence

  a_rdata_idle: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 16'h0)
    else $error("read data outside its cycle");
  a_sleep_gated: assert property (ed_only_out |-> !pll_en_out && !mac_en_out && !host_if_en_out)
    else $error("clocks alive in low-power state");
  a_sleep_min: assert property ($rose(ed_only_out) |-> idle_cnt_ff >= SLEEP_UNIT_CYC)
    else $error("sleep entered too early");
  a_energy_wake: assert property ((|energy_in) [*8] |-> !ed_only_out)
    else $error("energy did not end low-power state");
  a_pulse_energy: assert property ((|energy_in) [*8] |-> !link_pulse_out)
    else $error("link pulse with cable energy");
  a_pulse_width: assert property (disable iff (!rst_n_in || |energy_in)
    $rose(link_pulse_out) |-> link_pulse_out [*8] ##1 link_pulse_out [*4] ##1 !link_pulse_out)
    else $error("link pulse width wrong");
  a_spd_off: assert property (!pll_en_out && !ed_only_out && !int_rst_out |->
    phy_pd_out == 2'h3 && !mac_en_out && !host_if_en_out)
    else $error("soft power-down left blocks on");
  a_wake_clk: assert property ($rose(int_rst_out) |-> !pll_en_out ##1
    (pll_en_out && mac_en_out && host_if_en_out))
    else $error("wake did not restart clocks");
  a_wake_len: assert property ($rose(int_rst_out) |-> s_rst_half ##1 s_rst_half ##1 !int_rst_out)
    else $error("internal reset length wrong");
  a_psave_on: assert property (|phy_rx_idle_off_out |-> pll_en_out && mac_en_out && host_if_en_out)
    else $error("saving mode stopped clocks");
  a_rx_wake: assert property ((energy_in[1] || link_up_in[1]) [*8] |-> !phy_rx_idle_off_out[1])
    else $error("receiver kept off with activity");
endmodule // spm_power_chk

// *** verif/spm_cable_model.sv ***
`timescale 1ns/10ps
// ----------------------------------------
// Cable and far-end link partner
// ----------------------------------------
module spm_cable_model (
  // Clock and reset
  input  wire       sys_clk_in,
  input  wire       rst_n_in,
  // Cable plugged, per port
  input  wire [1:0] plug_in,
  // Line status towards the switch
  output reg  [1:0] energy_out,
  output reg  [1:0] link_up_out
);
  reg     [7:0] cnt_ff;
  integer       i;
  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      energy_out  <= 2'h0;
      link_up_out <= 2'h0;
      cnt_ff      <= 8'h0;
    end else begin
      energy_out <= plug_in;
      // Far end needs a while of energy before it brings link up
      for (i = 0; i < 2; i = i + 1) begin
        if (!plug_in[i]) cnt_ff[i*4 +: 4] <= 4'h0;
        else if (cnt_ff[i*4 +: 4] != 4'hf) cnt_ff[i*4 +: 4] <= cnt_ff[i*4 +: 4] + 4'h1;
        link_up_out[i] <= plug_in[i] && (cnt_ff[i*4 +: 4] > 4'h7);
      end
    end
  end
endmodule // spm_cable_model

// *** verif/testbench.sv ***
`timescale 1ns/10ps
`include "spm_regs.vh"
module testbench;
  reg         sys_clk_in;
  reg         rst_n_in;
  reg         clk_en_in;
  reg  [7:0]  reg_addr_in;
  reg  [15:0] reg_wdata_in;
  reg         reg_wr_in;
  reg         reg_rd_in;
  reg         host_sel_in;
  reg  [1:0]  plug;
  wire [15:0] reg_rdata_out;
  wire [1:0]  energy_in;
  wire [1:0]  link_up_in;
  wire        pll_en_out;
  wire        mac_en_out;
  wire        host_if_en_out;
  wire [1:0]  phy_pd_out;
  wire [1:0]  phy_rx_idle_off_out;
  wire        ed_only_out;
  wire        link_pulse_out;
  wire        int_rst_out;
  wire [15:0] flags;
  integer     mismatches;
  integer     total_checks;
  integer     cycles;
  integer     i;
  assign flags = {13'h0, pll_en_out, mac_en_out, host_if_en_out};

  // Short counts keep the run small
  spm_power_ctrl #(.SLEEP_UNIT_CYC(32'd4), .LP_PERIOD_CYC(32'd40)) i_dut (
    .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .clk_en_in(clk_en_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .energy_in(energy_in), .link_up_in(link_up_in),
    .host_sel_in(host_sel_in), .pll_en_out(pll_en_out), .mac_en_out(mac_en_out),
    .host_if_en_out(host_if_en_out), .phy_pd_out(phy_pd_out), .phy_rx_idle_off_out(phy_rx_idle_off_out),
    .ed_only_out(ed_only_out), .link_pulse_out(link_pulse_out), .int_rst_out(int_rst_out));
  spm_cable_model i_cable (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .plug_in(plug),
    .energy_out(energy_in), .link_up_out(link_up_in));

  initial begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end
  always @(posedge sys_clk_in) begin
    cycles = cycles + 1;
    if (cycles == 3000) begin
      mismatches = mismatches + 1;
      results;
    end
  end

  task chk(input [15:0] seen, input [15:0] exp);
    begin
      total_checks = total_checks + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task cyc(input integer n);
    begin
      repeat (n) @(posedge sys_clk_in);
      #1;
    end
  endtask
  task wr(input [7:0] a, input [15:0] d);
    begin
      @(posedge sys_clk_in);
      reg_addr_in  <= a;
      reg_wdata_in <= d;
      reg_wr_in    <= 1'b1;
      @(posedge sys_clk_in);
      reg_wr_in    <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [15:0] exp);
    begin
      @(posedge sys_clk_in);
      reg_addr_in <= a;
      reg_rd_in   <= 1'b1;
      @(posedge sys_clk_in);
      reg_rd_in   <= 1'b0;
      #1;
      chk(reg_rdata_out, exp);
    end
  endtask
  task results;
    begin
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask

  initial begin
    mismatches = 0;
    total_checks = 0;
    cycles = 0;
    rst_n_in = 1'b0;
    clk_en_in = 1'b1;
    reg_addr_in = 8'h00;
    reg_wdata_in = 16'h0000;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    host_sel_in = 1'b0;
    plug = 2'h0;
    repeat (3) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    cyc(6);
    chk(flags, 16'h0007);
    rd(`SPM_ADDR_GCTRL, `SPM_GCTRL_RST);
    rd(`SPM_ADDR_SLEEP, {8'h00, `SPM_SLEEP_RST});
    rd(8'h00, 16'h0000);
    // Clock enable low: a write in that window must not land
    @(posedge sys_clk_in);
    clk_en_in <= 1'b0;
    wr(`SPM_ADDR_PCTRL0, 16'h0008);
    @(posedge sys_clk_in);
    clk_en_in <= 1'b1;
    rd(`SPM_ADDR_PCTRL0, `SPM_PCTRL_RST);
    wr(`SPM_ADDR_PCTRL0, 16'h0008);
    cyc(2);
    chk({14'h0, phy_pd_out}, 16'h0001);
    wr(`SPM_ADDR_MIIM1, 16'h0800);
    wr(`SPM_ADDR_PCTRL0, 16'h0000);
    cyc(2);
    chk({14'h0, phy_pd_out}, 16'h0002);
    wr(`SPM_ADDR_MIIM1, 16'h0000);
    // Power saving, then a cable on port 1
    // Mode 11 without autoneg enable keeps the receivers whole
    wr(`SPM_ADDR_GCTRL, 16'h0018);
    cyc(3);
    chk({14'h0, phy_rx_idle_off_out, phy_pd_out}, 16'h0000);
    wr(`SPM_ADDR_GCTRL, 16'h0038);
    cyc(3);
    chk({14'h0, phy_rx_idle_off_out, phy_pd_out}, 16'h000c);
    chk(flags, 16'h0007);
    rd(`SPM_ADDR_GCTRL, 16'h0038);
    plug = 2'h2;
    cyc(20);
    chk({14'h0, phy_rx_idle_off_out}, 16'h0001);
    rd(`SPM_ADDR_STAT, 16'h0293);
    // Straight from saving to energy detect, then idle cable
    wr(`SPM_ADDR_SLEEP, 16'h0002);
    wr(`SPM_ADDR_GCTRL, 16'h0028);
    cyc(3);
    chk({14'h0, phy_rx_idle_off_out}, 16'h0000);
    plug = 2'h0;
    for (i = 0; i < 60 && link_pulse_out !== 1'b1; i = i + 1) cyc(1);
    chk({15'h0, link_pulse_out}, 16'h0001);
    // 120 ns wide at 100 MHz is 12 cycles; period is the test's 40
    cyc(11);
    chk({15'h0, link_pulse_out}, 16'h0001);
    cyc(1);
    chk({15'h0, link_pulse_out}, 16'h0000);
    cyc(28);
    chk({15'h0, link_pulse_out}, 16'h0001);
    for (i = 0; i < 200 && ed_only_out !== 1'b1; i = i + 1) cyc(1);
    chk({15'h0, ed_only_out}, 16'h0001);
    chk(flags, 16'h0000);
    rd(`SPM_ADDR_GCTRL, 16'h0000);
    plug = 2'h1;
    for (i = 0; i < 40 && ed_only_out !== 1'b0; i = i + 1) cyc(1);
    cyc(1);
    chk(flags, 16'h0007);
    rd(`SPM_ADDR_GCTRL, 16'h0028);
    // Soft power-down, woken by a read; the read itself is swallowed
    wr(`SPM_ADDR_GCTRL, 16'h0020);
    wr(`SPM_ADDR_PCTRL1, 16'h0008);
    wr(`SPM_ADDR_GCTRL, 16'h0030);
    cyc(2);
    chk({12'h0, phy_pd_out, pll_en_out, mac_en_out}, 16'h000c);
    rd(`SPM_ADDR_GCTRL, 16'h0000);
    chk({15'h0, int_rst_out}, 16'h0001);
    cyc(20);
    rd(`SPM_ADDR_PCTRL1, `SPM_PCTRL_RST);
    rd(`SPM_ADDR_GCTRL, `SPM_GCTRL_RST);
    // Wake by the select pin alone
    wr(`SPM_ADDR_GCTRL, 16'h0030);
    cyc(2);
    @(posedge sys_clk_in);
    host_sel_in <= 1'b1;
    for (i = 0; i < 20 && int_rst_out !== 1'b1; i = i + 1) cyc(1);
    chk({15'h0, int_rst_out}, 16'h0001);
    @(posedge sys_clk_in);
    host_sel_in <= 1'b0;
    cyc(20);
    chk(flags, 16'h0007);
    results;
  end
endmodule // testbench

bind spm_power_ctrl spm_power_chk #(.SLEEP_UNIT_CYC(SLEEP_UNIT_CYC), .LP_PERIOD_CYC(LP_PERIOD_CYC)) i_chk (
  .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .clk_en_in(clk_en_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
  .energy_in(energy_in), .link_up_in(link_up_in), .host_sel_in(host_sel_in), .pll_en_out(pll_en_out),
  .mac_en_out(mac_en_out), .host_if_en_out(host_if_en_out), .phy_pd_out(phy_pd_out),
  .phy_rx_idle_off_out(phy_rx_idle_off_out), .ed_only_out(ed_only_out), .link_pulse_out(link_pulse_out),
  .int_rst_out(int_rst_out));
